// ==== mac_pkg.sv ====
// constants for the multiply-accumulate engine register space and arithmetic
package mac_pkg;
   // register offsets in the special-function register space
   localparam logic [7:0] ADDR_STATUS = 8'hC0;
   localparam logic [7:0] ADDR_A_LOW = 8'hC1;
   localparam logic [7:0] ADDR_A_HIGH = 8'hC2;
   localparam logic [7:0] ADDR_CONFIG = 8'hC3;
   localparam logic [7:0] ADDR_ACC_BASE = 8'hC4;
   localparam logic [7:0] ADDR_B_HIGH = 8'hC9;
   localparam logic [7:0] ADDR_B_LOW = 8'hCA;
   localparam logic [7:0] ADDR_RND_LOW = 8'hCB;
   localparam logic [7:0] ADDR_RND_HIGH = 8'hCC;

   // configuration field positions
   localparam int CFG_MULTIPLY_ONLY = 0;
   localparam int CFG_FRACTIONAL = 1;
   localparam int CFG_SATURATE = 2;
   localparam int CFG_CLEAR = 3;
   localparam int CFG_SHIFT_DIR = 4;
   localparam int CFG_SHIFT = 5;
   localparam int CFG_WIDTH = 6;

   // status field positions
   localparam int STA_NEGATIVE = 0;
   localparam int STA_SOFT_OVF = 1;
   localparam int STA_ZERO = 2;
   localparam int STA_HARD_OVF = 3;
   localparam int STA_WIDTH = 4;

   // reset values
   localparam logic [7:0] RESET_STATUS = 8'h04;
   localparam logic [7:0] RESET_CONFIG = 8'h00;
   localparam logic [7:0] RESET_OPERAND = 8'h00;
   localparam logic [7:0] STATUS_CLEARED = 8'h00;

   // datapath widths
   localparam int ACC_WIDTH = 40;
   localparam int ACC_BYTES = 5;
   localparam int OPERAND_WIDTH = 16;
   localparam int PRODUCT_WIDTH = 32;

   // rounding and saturation values
   localparam logic [15:0] ROUND_HALF = 16'h8000;
   localparam logic [15:0] SAT_POSITIVE = 16'h7FFF;
   localparam logic [15:0] SAT_NEGATIVE = 16'h8000;
endpackage

// ==== mac_engine.sv ====
// multiply-accumulate engine with its special-function register port
// Behaviour
// - a write to operand B low byte starts one multiply or multiply-accumulate
// - operand A is sixteen bits: high byte is 15..8, low byte 7..0
// - shift bit shifts the 40-bit accumulator next cycle, then self-clears
// - shift direction bit: zero shifts left, one shifts right
// - clear bit zeroes accumulator and status next cycle, then self-clears
// - saturate bit lets the rounding result saturate on soft overflow or on rounding up from 0x7FFF
// - configuration bit 1 picks integer or fractional operands
// - configuration bit 0 picks accumulate or multiply-only, replacing the accumulator
// - unused configuration and status bits read zero and ignore writes
// - hard overflow sets on overflow byte wrap, clears by software or clear
// - zero flag follows whether the operation result is zero
// - soft overflow follows overflow into accumulator bit 31
// - negative flag follows the sign of the operation result
// - rounding register updates one cycle after an operation, a shift or a write to accumulator byte 0
// - three one-cycle stages; next operation may start in stage two
// - right shift copies bit 39; shifts leave the flags alone
// - rounding takes bits 31..16 and rounds half to even
// - saturated rounding result is 0x7FFF positive or 0x8000 negative
`timescale 1ns/1ps
`default_nettype none
module mac_engine
   import mac_pkg::*;
(
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic [7:0] SFR_ADDR,
   input wire logic SFR_WR,
   input wire logic [7:0] SFR_WDATA,
   input wire logic SFR_RD,
   output logic [7:0] SFR_RDATA
);

   logic [7:0] a_low_reg;
   logic [7:0] a_high_reg;
   logic [7:0] b_high_reg;
   logic [7:0] b_low_reg;
   logic [CFG_WIDTH-1:0] cfg_reg;
   logic [CFG_WIDTH-1:0] cfg_next;
   logic [STA_WIDTH-1:0] sta_reg;
   logic [STA_WIDTH-1:0] sta_next;
   logic [ACC_WIDTH-1:0] acc_reg;
   logic [ACC_WIDTH-1:0] acc_next;
   logic [15:0] rnd_reg;
   logic [7:0] rdata_reg;
   logic start_reg;
   logic prod_valid_reg;
   logic prod_only_reg;
   logic signed [PRODUCT_WIDTH-1:0] prod_reg;
   logic rnd_pending_reg;

   // register decode
   wire wr_status = SFR_WR && (SFR_ADDR == ADDR_STATUS);
   wire wr_a_low = SFR_WR && (SFR_ADDR == ADDR_A_LOW);
   wire wr_a_high = SFR_WR && (SFR_ADDR == ADDR_A_HIGH);
   wire wr_config = SFR_WR && (SFR_ADDR == ADDR_CONFIG);
   wire wr_b_high = SFR_WR && (SFR_ADDR == ADDR_B_HIGH);
   wire wr_b_low = SFR_WR && (SFR_ADDR == ADDR_B_LOW);

   // per-byte accumulator write decode and merge
   logic [ACC_BYTES-1:0] acc_byte_we;
   logic [ACC_WIDTH-1:0] acc_sw_merge;
   genvar gi;
   generate
      for (gi = 0; gi < ACC_BYTES; gi = gi + 1) begin : g_acc_byte
         assign acc_byte_we[gi] = SFR_WR && (SFR_ADDR == ADDR_ACC_BASE + 8'(gi));
         assign acc_sw_merge[8*gi +: 8] = acc_byte_we[gi] ? SFR_WDATA : acc_reg[8*gi +: 8];
      end
   endgenerate
   wire acc_sw_write = |acc_byte_we;

   // stage one multiply on the latched operands
   // operand A and B assembly
   wire signed [OPERAND_WIDTH-1:0] operand_a = {a_high_reg, a_low_reg};
   wire signed [OPERAND_WIDTH-1:0] operand_b = {b_high_reg, b_low_reg};
   wire signed [PRODUCT_WIDTH-1:0] raw_product = operand_a * operand_b;
   wire signed [PRODUCT_WIDTH-1:0] aligned_product =
      cfg_reg[CFG_FRACTIONAL] ? (raw_product <<< 1) : raw_product;

   // stage two add into the accumulator
   wire [ACC_WIDTH-1:0] product_ext = {{(ACC_WIDTH-PRODUCT_WIDTH){prod_reg[PRODUCT_WIDTH-1]}},
                                       prod_reg};
   wire [ACC_WIDTH-1:0] addend = prod_only_reg ? '0 : acc_reg;
   wire [ACC_WIDTH-1:0] sum = addend + product_ext;
   // overflow byte wrap equals signed 40-bit overflow
   wire hard_ovf = !prod_only_reg && (addend[ACC_WIDTH-1] == product_ext[ACC_WIDTH-1])
                   && (sum[ACC_WIDTH-1] != addend[ACC_WIDTH-1]);
   // bits 39..31 not a pure sign extension
   wire sum_soft_ovf = !((&sum[ACC_WIDTH-1:31]) || !(|sum[ACC_WIDTH-1:31]));

   // accumulator shift
   // direction bit picks side
   // arithmetic right shift keeps bit 39
   wire [ACC_WIDTH-1:0] acc_shifted = cfg_reg[CFG_SHIFT_DIR] ?
      {acc_reg[ACC_WIDTH-1], acc_reg[ACC_WIDTH-1:1]} : {acc_reg[ACC_WIDTH-2:0], 1'b0};

   // rounding engine on the current accumulator
   wire [15:0] rnd_low = acc_reg[15:0];
   wire [15:0] rnd_high = acc_reg[31:16];
   // half rounds up only on odd
   wire rnd_up = (rnd_low > ROUND_HALF) || ((rnd_low == ROUND_HALF) && rnd_high[0]);
   wire [15:0] rnd_value = rnd_high + {15'h0000, rnd_up};
   wire acc_soft_ovf = !((&acc_reg[ACC_WIDTH-1:31]) || !(|acc_reg[ACC_WIDTH-1:31]));
   wire rnd_ovf = acc_soft_ovf || (rnd_up && (rnd_high == SAT_POSITIVE));
   wire [15:0] rnd_result = (cfg_reg[CFG_SATURATE] && rnd_ovf) ?
      (acc_reg[ACC_WIDTH-1] ? SAT_NEGATIVE : SAT_POSITIVE) : rnd_value;

   // configuration next value: software write, then hardware self-clear
   always_comb begin
      cfg_next = cfg_reg;
      if (wr_config) begin
         cfg_next = SFR_WDATA[CFG_WIDTH-1:0];
      end else begin
         if (cfg_reg[CFG_SHIFT]) begin
            cfg_next[CFG_SHIFT] = 1'b0;
         end
         if (cfg_reg[CFG_CLEAR]) begin
            cfg_next[CFG_CLEAR] = 1'b0;
         end
      end
   end

   // accumulator next value, clear first, then operation, shift, software
   always_comb begin
      acc_next = acc_reg;
      if (cfg_reg[CFG_CLEAR]) begin
         acc_next = '0;
      end else if (prod_valid_reg) begin
         acc_next = sum;
      end else if (cfg_reg[CFG_SHIFT]) begin
         acc_next = acc_shifted;
      end else if (acc_sw_write) begin
         acc_next = acc_sw_merge;
      end
   end

   // status next value; hardware set of hard overflow beats a software clear
   always_comb begin
      sta_next = sta_reg;
      if (wr_status) begin
         sta_next = SFR_WDATA[STA_WIDTH-1:0];
      end
      if (cfg_reg[CFG_CLEAR]) begin
         sta_next = STATUS_CLEARED[STA_WIDTH-1:0];
      end else if (prod_valid_reg) begin
         sta_next[STA_ZERO] = (sum == '0);
         sta_next[STA_NEGATIVE] = sum[ACC_WIDTH-1];
         sta_next[STA_SOFT_OVF] = sum_soft_ovf;
         sta_next[STA_HARD_OVF] = sta_next[STA_HARD_OVF] | hard_ovf;
      end
   end

   // read mux, unmapped addresses read zero
   logic [7:0] read_mux;
   always_comb begin
      read_mux = 8'h00;
      if (SFR_ADDR == ADDR_STATUS) begin
         read_mux = {4'h0, sta_reg};
      end else if (SFR_ADDR == ADDR_A_LOW) begin
         read_mux = a_low_reg;
      end else if (SFR_ADDR == ADDR_A_HIGH) begin
         read_mux = a_high_reg;
      end else if (SFR_ADDR == ADDR_CONFIG) begin
         read_mux = {2'b00, cfg_reg};
      end else if (SFR_ADDR == ADDR_B_HIGH) begin
         read_mux = b_high_reg;
      end else if (SFR_ADDR == ADDR_B_LOW) begin
         read_mux = b_low_reg;
      end else if (SFR_ADDR == ADDR_RND_LOW) begin
         read_mux = rnd_reg[7:0];
      end else if (SFR_ADDR == ADDR_RND_HIGH) begin
         read_mux = rnd_reg[15:8];
      end else begin
         for (int k = 0; k < ACC_BYTES; k++) begin
            if (SFR_ADDR == ADDR_ACC_BASE + 8'(k)) begin
               read_mux = acc_reg[8*k +: 8];
            end
         end
      end
   end

   // operand registers
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         a_low_reg <= RESET_OPERAND;
         a_high_reg <= RESET_OPERAND;
         b_high_reg <= RESET_OPERAND;
         b_low_reg <= RESET_OPERAND;
      end else begin
         if (wr_a_low) a_low_reg <= SFR_WDATA;
         if (wr_a_high) a_high_reg <= SFR_WDATA;
         if (wr_b_high) b_high_reg <= SFR_WDATA;
         if (wr_b_low) b_low_reg <= SFR_WDATA;
      end
   end

   // pipeline control: start, stage one product, rounding strobe
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         start_reg <= 1'b0;
         prod_valid_reg <= 1'b0;
         prod_only_reg <= 1'b0;
         prod_reg <= '0;
         rnd_pending_reg <= 1'b0;
      end else begin
         // operand B low write starts an operation
         start_reg <= wr_b_low;
         prod_valid_reg <= start_reg;
         if (start_reg) begin
            prod_reg <= aligned_product;
            prod_only_reg <= cfg_reg[CFG_MULTIPLY_ONLY];
         end
         // round one cycle after an operation, a shift or a write to accumulator byte 0
         rnd_pending_reg <= prod_valid_reg || (cfg_reg[CFG_SHIFT] && !cfg_reg[CFG_CLEAR])
                            || acc_byte_we[0];
      end
   end

   // state registers and read data
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         cfg_reg <= RESET_CONFIG[CFG_WIDTH-1:0];
         sta_reg <= RESET_STATUS[STA_WIDTH-1:0];
         acc_reg <= '0;
         rnd_reg <= '0;
         rdata_reg <= 8'h00;
      end else begin
         cfg_reg <= cfg_next;
         sta_reg <= sta_next;
         acc_reg <= acc_next;
         if (rnd_pending_reg) rnd_reg <= rnd_result;
         if (SFR_RD) rdata_reg <= read_mux;
      end
   end

   assign SFR_RDATA = rdata_reg;

endmodule
`default_nettype wire

// ==== mac_engine_props.sv ====
// assertion checker watching the mac engine register port
`timescale 1ns/1ps
`default_nettype none
module mac_engine_props
   import mac_pkg::*;
(
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic [7:0] SFR_ADDR,
   input wire logic SFR_WR,
   input wire logic [7:0] SFR_WDATA,
   input wire logic SFR_RD,
   input wire logic [7:0] SFR_RDATA
);
   default clocking @(posedge CLK); endclocking
   default disable iff (!RST_B);
   // strobes decoded per register
   wire wr_cfg = SFR_WR && SFR_ADDR == ADDR_CONFIG;
   wire wr_sta = SFR_WR && SFR_ADDR == ADDR_STATUS;
   wire wr_bl = SFR_WR && SFR_ADDR == ADDR_B_LOW;
   wire rd_cfg = SFR_RD && SFR_ADDR == ADDR_CONFIG;
   wire rd_sta = SFR_RD && SFR_ADDR == ADDR_STATUS;
   wire rd_bl = SFR_RD && SFR_ADDR == ADDR_B_LOW;
   unmapped_read_a: assert property (SFR_RD && (SFR_ADDR < ADDR_STATUS ||
      SFR_ADDR > ADDR_RND_HIGH) |=> SFR_RDATA == 8'h00) else $error("unmapped read not zero");
   cfg_unused_a: assert property (rd_cfg |=> SFR_RDATA[7:6] == 2'b00)
      else $error("config top bits not zero");
   sta_unused_a: assert property (rd_sta |=> SFR_RDATA[7:4] == 4'h0)
      else $error("status top bits not zero");
   cfg_readback_a: assert property (wr_cfg ##1 !SFR_WR [*3] ##1 rd_cfg
      |=> SFR_RDATA == ($past(SFR_WDATA, 5) & 8'h17)) else $error("config readback wrong");
   clear_status_a: assert property (wr_cfg && SFR_WDATA[CFG_CLEAR] ##1 !SFR_WR [*2]
      ##1 rd_sta |=> SFR_RDATA == STATUS_CLEARED) else $error("clear left status flags");
   status_write_a: assert property (wr_sta ##1 !SFR_WR [*2] ##1 rd_sta
      |=> SFR_RDATA == ($past(SFR_WDATA, 4) & 8'h0F)) else $error("status write wrong");
   trigger_keep_a: assert property (wr_bl ##1 !SFR_WR [*4] ##1 rd_bl
      |=> SFR_RDATA == $past(SFR_WDATA, 6)) else $error("operand b low lost");
   rdata_hold_a: assert property (!SFR_RD |=> $stable(SFR_RDATA))
      else $error("read data moved without a read");
endmodule
`default_nettype wire

// ==== mac_core_model.sv ====
// processor core model driving the special-function register port
`timescale 1ns/1ps
`default_nettype none
module mac_core_model (
   input wire logic clk,
   output var logic [7:0] sfr_addr,
   output var logic sfr_wr,
   output var logic [7:0] sfr_wdata,
   output var logic sfr_rd
);
   // idle bus at time zero
   initial begin
      sfr_addr = 8'h00;
      sfr_wr = 1'b0;
      sfr_wdata = 8'h00;
      sfr_rd = 1'b0;
   end
   // one bus cycle held through the next edge; idle cycles scramble stale values
   task automatic cycle(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
      sfr_wr = w;
      sfr_rd = r;
      sfr_addr = (w || r) ? a : ~sfr_addr;
      sfr_wdata = w ? d : ~sfr_wdata;
      @(posedge clk);
      #1;
   endtask
endmodule
`default_nettype wire

// ==== mac_engine_test.sv ====
// self-checking bench for the mac engine with a register-level model
`timescale 1ns/1ps
`default_nettype none
module mac_engine_test
   import mac_pkg::*;
;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   wire logic [7:0] addr, wdata, rdata;
   wire logic wr, rd;
   int num_errors = 0;
   int num_checks = 0;
   integer seed = 32'hD8DAD0A8;
   logic [39:0] acc_m = '0;
   logic [15:0] a_m = '0, b_m = '0, rnd_m = '0;
   logic [3:0] sta_m = 4'h4;
   logic [7:0] cfg_m = '0;
   logic [7:0] ord [16] = '{8'hC0, 8'hC3, 8'hCA, 8'hC1, 8'hC2, 8'hC4, 8'hC5, 8'hC6,
      8'hC7, 8'hC8, 8'hC9, 8'hCB, 8'hCC, 8'hCD, 8'hCF, 8'h00};
   mac_core_model i_core (.clk(clk), .sfr_addr(addr), .sfr_wr(wr), .sfr_wdata(wdata), .sfr_rd(rd));
   mac_engine i_dut (.CLK(clk), .RST_B(rst_b), .SFR_ADDR(addr), .SFR_WR(wr),
      .SFR_WDATA(wdata), .SFR_RD(rd), .SFR_RDATA(rdata));
   initial forever #10 clk = ~clk;
   task automatic report_and_stop();
      $display("checks %0d errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [7:0] a, input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("CHECK FAILED reg %h expected %h seen %h", a, exp, seen);
      end
   endtask
   // model rounding: half to even on bits 31..16, optional saturation
   function automatic logic [15:0] rnd_f();
      logic up;
      up = acc_m[15:0] > 16'h8000 || (acc_m[15:0] == 16'h8000 && acc_m[16]);
      if (cfg_m[CFG_SATURATE] && (so_f(acc_m) || (up && acc_m[31:16] == 16'h7FFF)))
         return acc_m[39] ? SAT_NEGATIVE : SAT_POSITIVE;
      return acc_m[31:16] + 16'(up);
   endfunction
   function automatic logic so_f(input logic [39:0] v);
      return !(&v[39:31] || !(|v[39:31]));
   endfunction
   function automatic logic [7:0] ex(input logic [7:0] a);
      case (a)
         ADDR_STATUS: return {4'h0, sta_m};
         ADDR_A_LOW: return a_m[7:0];
         ADDR_A_HIGH: return a_m[15:8];
         ADDR_CONFIG: return cfg_m;
         ADDR_B_HIGH: return b_m[15:8];
         ADDR_B_LOW: return b_m[7:0];
         ADDR_RND_LOW: return rnd_m[7:0];
         ADDR_RND_HIGH: return rnd_m[15:8];
         default: return (a >= ADDR_ACC_BASE && a < ADDR_B_HIGH) ? acc_m[(a - ADDR_ACC_BASE) * 8 +: 8] : 8'h00;
      endcase
   endfunction
   // register write: model follows, then the core drives the bus
   task automatic wr_m(input logic [7:0] a, input logic [7:0] d);
      logic [31:0] p;
      logic [39:0] pe, s;
      case (a)
         ADDR_STATUS: sta_m = d[3:0];
         ADDR_A_LOW: a_m[7:0] = d;
         ADDR_A_HIGH: a_m[15:8] = d;
         ADDR_B_HIGH: b_m[15:8] = d;
         ADDR_CONFIG: begin
            cfg_m = d & 8'h17;
            if (d[CFG_SHIFT]) begin
               acc_m = d[CFG_SHIFT_DIR] ? {acc_m[39], acc_m[39:1]} : acc_m << 1;
               rnd_m = rnd_f();
            end
            if (d[CFG_CLEAR]) begin
               acc_m = '0;
               sta_m = 4'h0;
            end
         end
         ADDR_B_LOW: begin
            b_m[7:0] = d;
            p = $signed(a_m) * $signed(b_m);
            p = cfg_m[CFG_FRACTIONAL] ? p << 1 : p;
            pe = {{8{p[31]}}, p};
            s = cfg_m[CFG_MULTIPLY_ONLY] ? pe : acc_m + pe;
            sta_m = {sta_m[3] | (!cfg_m[0] && acc_m[39] == pe[39] && s[39] != acc_m[39]),
               s == 40'h0, so_f(s), s[39]};
            acc_m = s;
            rnd_m = rnd_f();
         end
         default: if (a >= ADDR_ACC_BASE && a < ADDR_B_HIGH) begin
            acc_m[(a - ADDR_ACC_BASE) * 8 +: 8] = d;
            if (a == ADDR_ACC_BASE) rnd_m = rnd_f();
         end
      endcase
      i_core.cycle(1'b1, 1'b0, a, d);
   endtask
   // two idle cycles let any operation drain, then every register is read
   task automatic check_all();
      // no trigger or config write while draining
      i_core.cycle(1'b0, 1'b0, 8'h00, 8'h00);
      i_core.cycle(1'b0, 1'b0, 8'h00, 8'h00);
      for (int i = 0; i < 16; i++) begin
         i_core.cycle(1'b0, 1'b1, ord[i], 8'h00);
         chk(ord[i], rdata, ex(ord[i]));
      end
   endtask
   // operands loaded, operand b low written last to trigger
   task automatic op(input logic [15:0] a, input logic [15:0] b);
      wr_m(ADDR_A_HIGH, a[15:8]);
      wr_m(ADDR_A_LOW, a[7:0]);
      wr_m(ADDR_B_HIGH, b[15:8]);
      wr_m(ADDR_B_LOW, b[7:0]);
   endtask
   // reads straddle the edges where the result and the rounding land
   task automatic op_timed(input logic [15:0] a, input logic [15:0] b);
      logic [7:0] acc_old;
      logic [7:0] rnd_old;
      acc_old = acc_m[7:0];
      rnd_old = rnd_m[7:0];
      op(a, b);
      i_core.cycle(1'b0, 1'b0, 8'h00, 8'h00);
      i_core.cycle(1'b0, 1'b1, ADDR_ACC_BASE, 8'h00);
      chk(ADDR_ACC_BASE, rdata, acc_old);
      i_core.cycle(1'b0, 1'b1, ADDR_RND_LOW, 8'h00);
      chk(ADDR_RND_LOW, rdata, rnd_old);
      i_core.cycle(1'b0, 1'b1, ADDR_RND_LOW, 8'h00);
      chk(ADDR_RND_LOW, rdata, rnd_m[7:0]);
   endtask
   task automatic load_acc(input logic [39:0] v);
      for (int k = 4; k >= 0; k--) wr_m(8'(ADDR_ACC_BASE + k), v[k * 8 +: 8]);
   endtask
   // main sequence; no config or status write while an operation drains
   initial begin
      repeat (10) @(posedge clk);
      #1 rst_b = 1'b1;
      check_all();
      wr_m(ADDR_CONFIG, 8'h0A);
      op(16'h4000, 16'h2000);
      op(16'h4000, 16'hE000);
      check_all();
      wr_m(ADDR_CONFIG, 8'h01);
      op(16'h1234, 16'hFEDC);
      check_all();
      load_acc(40'h4088442211);
      wr_m(ADDR_CONFIG, 8'h20);
      check_all();
      wr_m(ADDR_CONFIG, 8'h30);
      wr_m(ADDR_CONFIG, 8'h30);
      wr_m(8'hD0, 8'h5A);
      wr_m(ADDR_RND_LOW, 8'hA5);
      check_all();
      load_acc(40'h7FFFFFFFFF);
      wr_m(ADDR_CONFIG, 8'h00);
      op(16'h0001, 16'h0001);
      check_all();
      wr_m(ADDR_CONFIG, 8'h08);
      check_all();
      wr_m(ADDR_STATUS, 8'hFA);
      check_all();
      for (int sgn = 0; sgn < 2; sgn++) begin
         wr_m(ADDR_CONFIG, 8'h0C);
         repeat (3) begin
            op(sgn ? 16'h8000 : 16'h7FFF, 16'h7FFF);
            check_all();
         end
      end
      repeat (24) begin
         wr_m(ADDR_CONFIG, 8'($random(seed)) & 8'h07);
         op_timed(16'($random(seed)), 16'($random(seed)));
         check_all();
      end
      report_and_stop();
   end
   // hang guard
   initial begin
      repeat (20000) @(posedge clk);
      num_errors++;
      report_and_stop();
   end
endmodule
bind mac_engine mac_engine_props i_props (.CLK(CLK), .RST_B(RST_B), .SFR_ADDR(SFR_ADDR),
   .SFR_WR(SFR_WR), .SFR_WDATA(SFR_WDATA), .SFR_RD(SFR_RD), .SFR_RDATA(SFR_RDATA));
`default_nettype wire
